// >>> dv/eeprom_model.sv
// Behavioural model of the serial three-wire configuration EEPROM.
`timescale 1ns/1ns
module eeprom_model (
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  output logic serial_out
);
  logic [15:0] mem [0:63];
  logic [15:0] shift_reg;
  logic [8:0] cmd_reg = 9'h000;
  int bit_cnt = 0;
  logic reading = 1'b0;

  initial begin
    serial_out = 1'b0;
  end

  // Command bits are taken on the rising clock; zeros before the start bit are ignored.
  always @(posedge serial_clock) begin
    if (chip_select && !reading && (bit_cnt > 0 || serial_in)) begin
      cmd_reg = {cmd_reg[7:0], serial_in};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 9 && cmd_reg[8:6] == 3'h6) begin
        shift_reg = mem[cmd_reg[5:0]];
        reading = 1'b1;
      end
    end
    if (!reading) begin
      // Outside a read the output is meaningless, so a stale level must never pass for data.
      serial_out = ~serial_out;
    end
  end

  // Each falling clock presents the next data bit, most significant first.
  always @(negedge serial_clock) begin
    if (chip_select && reading) begin
      serial_out = shift_reg[15];
      shift_reg = {shift_reg[14:0], 1'b0};
    end
  end

  // Dropping chip select ends the access and lets the output wander.
  always @(negedge chip_select) begin
    reading = 1'b0;
    bit_cnt = 0;
    serial_out = ~serial_out;
  end
endmodule // eeprom_model

// >>> dv/tb_eeprom_config_autoload_and_id.sv
// Self-checking testbench for the EEPROM configuration loader and identification registers.
`timescale 1ns/1ns
module tb_eeprom_config_autoload_and_id
  import eeprom_cfg_pkg::*;
;
  localparam int HALF = 4;
  localparam logic [7:0] ODD = 8'h3C;  // Arbitrary value.
  localparam logic [7:0] EVEN = 8'hC3;  // Arbitrary value.
  localparam int LIMIT = 20000;

  logic CORE_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic SM_WR = 1'b0;
  logic [15:0] SM_WDATA = 16'h0000;
  logic [15:0] SM_RDATA;
  logic SIG_RD = 1'b0;
  logic SIG_DRV_WR = 1'b0;
  logic [15:0] SIG_DRV_WDATA = 16'h0000;
  logic [31:0] SIG_RDATA;
  logic CFG_RD_REQ = 1'b0;
  logic CFG_RD_ACK, LOAD_DONE;
  cfg_image_t CONFIG;
  logic [31:0] VENDOR_DEVICE_ID_REG, REVISION_REG;
  logic EEPROM_CHIP_SELECT, EEPROM_SERIAL_CLOCK_O, EEPROM_SERIAL_CLOCK_OE_N;
  logic EEPROM_SERIAL_IN_O, EEPROM_SERIAL_IN_OE_N, EEPROM_SERIAL_OUT;
  logic ee_sk, ee_di;
  int seed = 21061;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int ack_cnt = 0;
  logic early_ack = 1'b0;
  logic sig_odd = 1'b1;
  logic sig_taken = 1'b0;
  logic [7:0] sig_exp = 8'h00;
  logic [31:0] vd_exp;
  logic [15:0] w, d;
  int k;

  always #10 CORE_CLK = ~CORE_CLK;

  // Released clock and data lines sit at their pull-down level.
  assign ee_sk = EEPROM_SERIAL_CLOCK_OE_N ? 1'b0 : EEPROM_SERIAL_CLOCK_O;
  assign ee_di = EEPROM_SERIAL_IN_OE_N ? 1'b0 : EEPROM_SERIAL_IN_O;

  eeprom_config_autoload #(.HALF_CYCLES(HALF), .SIG_ODD_BYTE(ODD), .SIG_EVEN_BYTE(EVEN)) i_dut (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .SM_WR(SM_WR), .SM_WDATA(SM_WDATA), .SM_RDATA(SM_RDATA),
    .SIG_RD(SIG_RD), .SIG_DRV_WR(SIG_DRV_WR), .SIG_DRV_WDATA(SIG_DRV_WDATA), .SIG_RDATA(SIG_RDATA),
    .CFG_RD_REQ(CFG_RD_REQ), .CFG_RD_ACK(CFG_RD_ACK), .LOAD_DONE(LOAD_DONE), .CONFIG(CONFIG),
    .VENDOR_DEVICE_ID_REG(VENDOR_DEVICE_ID_REG), .REVISION_REG(REVISION_REG),
    .EEPROM_CHIP_SELECT(EEPROM_CHIP_SELECT), .EEPROM_SERIAL_CLOCK_O(EEPROM_SERIAL_CLOCK_O),
    .EEPROM_SERIAL_CLOCK_OE_N(EEPROM_SERIAL_CLOCK_OE_N), .EEPROM_SERIAL_IN_O(EEPROM_SERIAL_IN_O),
    .EEPROM_SERIAL_IN_OE_N(EEPROM_SERIAL_IN_OE_N), .EEPROM_SERIAL_OUT(EEPROM_SERIAL_OUT)
  );

  eeprom_model i_ee (
    .chip_select(EEPROM_CHIP_SELECT), .serial_clock(ee_sk), .serial_in(ee_di), .serial_out(EEPROM_SERIAL_OUT)
  );

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task end_of_test;
    $display("Checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // The cycle ceiling cuts a hang short; acks are tallied and flagged if they beat the load.
  always @(posedge CORE_CLK) begin
    cycles++;
    if (CFG_RD_ACK === 1'b1) begin
      ack_cnt++;
      if (LOAD_DONE !== 1'b1) early_ack <= 1'b1;
    end
    if (cycles >= LIMIT) begin
      bad_count++;
      end_of_test();
    end
  end

  // Expected serial management readback; bit 3 is masked because it shows the pin.
  function automatic logic [15:0] sm_expect(input logic [15:0] v);
    sm_expect = 16'h0000;
    sm_expect[7:0] = v[7:0];
    sm_expect[SM_DO_BIT] = 1'b0;
    sm_expect[SM_EE_EN_BIT] = v[SM_EE_EN_BIT];
  endfunction

  // Expected pins after a write: driven from the port bits when enabled, released otherwise.
  function automatic logic [4:0] pins_expect(input logic [15:0] v);
    if (v[SM_EE_EN_BIT]) begin
      pins_expect = {v[SM_CS_BIT], v[SM_SK_BIT], v[SM_DI_BIT], 2'b00};
    end else begin
      pins_expect = 5'b00011;
    end
  endfunction

  // Expected signature byte alternates from the first read after each hardware reset.
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sig_odd <= 1'b1;
      sig_taken <= 1'b0;
    end else begin
      sig_taken <= SIG_RD;
      if (SIG_RD) begin
        sig_exp <= sig_odd ? ODD : EVEN;
        sig_odd <= ~sig_odd;
      end
    end
  end

  // Sampled mid-cycle so the registered answer has settled.
  always @(negedge CORE_CLK) begin
    if (sig_taken) begin
      check("signature", SIG_RDATA[7:0], sig_exp);
      check("signature_pad", SIG_RDATA[15:8], 8'h00);
    end
  end

  // ----------------------------------------------------------------
  // Stimulus tasks
  // ----------------------------------------------------------------
  task automatic sm_write(input logic [15:0] v);
    @(posedge CORE_CLK) begin
      SM_WR <= 1'b1;
      SM_WDATA <= v;
    end
    @(posedge CORE_CLK) SM_WR <= 1'b0;
    repeat (8) @(negedge CORE_CLK);  // Covers pin lag and the serial-out synchroniser.
  endtask

  // Software read of one word by toggling the port bits; the host reads data after each fall.
  task automatic bb_read(input logic [5:0] a);
    logic [8:0] cmd;
    int j;
    cmd = {3'h6, a};
    sm_write(16'h0800);
    sm_write(16'h0801);
    for (j = 8; j >= 0; j--) begin
      sm_write({4'h0, 1'b1, 8'h00, cmd[j], 2'b01});
      sm_write({4'h0, 1'b1, 8'h00, cmd[j], 2'b11});
    end
    sm_write(16'h0801);
    for (j = 15; j >= 0; j--) begin
      d[j] = SM_RDATA[3];
      if (j > 0) begin
        sm_write(16'h0803);
        sm_write(16'h0801);
      end
    end
    sm_write(16'h0000);
    check("bitbang_word", d, i_ee.mem[a]);
    $display("Bit-bang read of word %0d done", a);
  endtask

  task automatic sig_burst;
    int n;
    for (n = 0; n < 24; n++) @(posedge CORE_CLK) SIG_RD <= 1'($random(seed));
    @(posedge CORE_CLK) SIG_RD <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    $display("Signature test done");
  endtask

  // Fresh EEPROM image, hardware reset, then every loaded field against the image.
  task automatic load_and_check;
    int n;
    for (n = 0; n < 64; n++) i_ee.mem[n] = 16'($random(seed));
    @(posedge CORE_CLK) ARST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    CFG_RD_REQ <= 1'b1;
    ack_cnt = 0;
    for (n = 0; n < 6000 && LOAD_DONE !== 1'b1; n++) @(negedge CORE_CLK);
    check("load_done", LOAD_DONE, 1'b1);
    check("early_ack", early_ack, 1'b0);
    repeat (4) @(negedge CORE_CLK);
    check("ack_after_load", ack_cnt > 0, 1'b1);
    check("station", CONFIG.station_addr, {i_ee.mem[2], i_ee.mem[1], i_ee.mem[0]});
    check("max_latency", CONFIG.max_latency, i_ee.mem[3][15:8]);
    check("min_grant", CONFIG.min_grant, i_ee.mem[3][7:0]);
    check("subsys_id", CONFIG.subsys_id, i_ee.mem[4]);
    check("subsys_vendor", CONFIG.subsys_vendor_id, i_ee.mem[5]);
    check("device_id", CONFIG.device_id, i_ee.mem[6]);
    check("vendor_id", CONFIG.vendor_id, i_ee.mem[7]);
    check("revision", CONFIG.revision, i_ee.mem[8][7:0]);
    check("options", CONFIG.power_wake_bootsize_byte, i_ee.mem[8][15:8]);
    vd_exp = {i_ee.mem[6], i_ee.mem[7]};
    check("vendor_device", VENDOR_DEVICE_ID_REG, vd_exp);
    check("revision_reg", REVISION_REG, {ETH_CLASS_CODE, i_ee.mem[8][7:0]});
    @(posedge CORE_CLK) CFG_RD_REQ <= 1'b0;
    $display("Autoload test done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    load_and_check();
    sig_burst();
    for (k = 0; k < 4; k++) begin
      w = 16'($random(seed));
      @(posedge CORE_CLK) begin
        SIG_DRV_WR <= 1'b1;
        SIG_DRV_WDATA <= w;
      end
      @(posedge CORE_CLK) SIG_DRV_WR <= 1'b0;
      @(negedge CORE_CLK) check("driver_area", SIG_RDATA[31:16], w);
    end
    $display("Driver area test done");
    for (k = 0; k < 8; k++) begin
      w = 16'($random(seed));
      w[11] = k[0];
      sm_write(w);
      check("sm_readback", SM_RDATA & 16'hFFF7, sm_expect(w));
      check("pins", {EEPROM_CHIP_SELECT, EEPROM_SERIAL_CLOCK_O, EEPROM_SERIAL_IN_O, EEPROM_SERIAL_CLOCK_OE_N,
            EEPROM_SERIAL_IN_OE_N}, pins_expect(w));
    end
    $display("General port test done");
    bb_read(6'h08);
    bb_read(6'($random(seed)));
    i_ee.mem[7] = ~i_ee.mem[7];
    i_ee.mem[6] = ~i_ee.mem[6];
    bb_read(6'h07);
    check("vendor_device_held", VENDOR_DEVICE_ID_REG, vd_exp);
    load_and_check();
    sig_burst();
    end_of_test();
  end
endmodule // tb_eeprom_config_autoload_and_id

// >>> verilog/eeprom_cfg_pkg.sv
// Constants and types shared by the EEPROM configuration loader.
package eeprom_cfg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_PERIOD_NS = 20;
  localparam int EE_SK_HALF_MIN_NS = 1000;
  // Least time, so the count rounds up to whole core cycles.
  localparam int EE_SK_HALF_CYC = (EE_SK_HALF_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Serial read sequence
  // ----------------------------------------------------------------
  localparam int LOAD_WORDS = 9;
  localparam int CMD_BITS = 9;
  localparam int DATA_BITS = 16;
  localparam logic [2:0] EE_READ_PREFIX = 3'h6;
  localparam logic [3:0] WORD_STATION_0 = 4'h0;
  localparam logic [3:0] WORD_STATION_1 = 4'h1;
  localparam logic [3:0] WORD_STATION_2 = 4'h2;
  localparam logic [3:0] WORD_LAT_GNT = 4'h3;
  localparam logic [3:0] WORD_SUBSYS_ID = 4'h4;
  localparam logic [3:0] WORD_SUBSYS_VENDOR = 4'h5;
  localparam logic [3:0] WORD_DEVICE_ID = 4'h6;
  localparam logic [3:0] WORD_VENDOR_ID = 4'h7;
  localparam logic [3:0] WORD_REV_OPTIONS = 4'h8;

  // ----------------------------------------------------------------
  // Serial management register fields and built-in codes
  // ----------------------------------------------------------------
  localparam int SM_CS_BIT = 0;
  localparam int SM_SK_BIT = 1;
  localparam int SM_DI_BIT = 2;
  localparam int SM_DO_BIT = 3;
  localparam int SM_EE_EN_BIT = 11;
  localparam logic [23:0] ETH_CLASS_CODE = 24'h020000;
  localparam logic [15:0] DRIVER_AREA_RESET = 16'h0000;

  typedef enum logic [2:0] {
    LD_START = 3'h0,
    LD_SEND = 3'h1,
    LD_RECV = 3'h3,
    LD_GAP = 3'h2,
    LD_DONE = 3'h6
  } load_state_t;

  typedef struct packed {
    logic [47:0] station_addr;
    logic [7:0] max_latency;
    logic [7:0] min_grant;
    logic [15:0] subsys_id;
    logic [15:0] subsys_vendor_id;
    logic [15:0] device_id;
    logic [15:0] vendor_id;
    logic [7:0] revision;
    logic [7:0] power_wake_bootsize_byte;
  } cfg_image_t;

endpackage

// >>> verilog/eeprom_config_autoload.sv
// EEPROM configuration autoload, identification registers and bit-banged EEPROM port.
`timescale 1ns/1ns
module eeprom_config_autoload
  import eeprom_cfg_pkg::*;
#(
  parameter int HALF_CYCLES = EE_SK_HALF_CYC,
  parameter logic [7:0] SIG_ODD_BYTE = 8'hA5,  // Arbitrary value.
  parameter logic [7:0] SIG_EVEN_BYTE = 8'h5A  // Arbitrary value.
) (
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic SM_WR,
  input wire logic [15:0] SM_WDATA,
  output logic [15:0] SM_RDATA,
  input wire logic SIG_RD,
  input wire logic SIG_DRV_WR,
  input wire logic [15:0] SIG_DRV_WDATA,
  output logic [31:0] SIG_RDATA,
  input wire logic CFG_RD_REQ,
  output logic CFG_RD_ACK,
  output logic LOAD_DONE,
  output cfg_image_t CONFIG,
  output logic [31:0] VENDOR_DEVICE_ID_REG,
  output logic [31:0] REVISION_REG,
  output logic EEPROM_CHIP_SELECT,
  output logic EEPROM_SERIAL_CLOCK_O,
  output logic EEPROM_SERIAL_CLOCK_OE_N,
  output logic EEPROM_SERIAL_IN_O,
  output logic EEPROM_SERIAL_IN_OE_N,
  input wire logic EEPROM_SERIAL_OUT
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  // The reset enters asynchronously but is released on two clock edges.
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Serial-out pin synchroniser and latch
  // ----------------------------------------------------------------
  logic do_s1_reg, do_s2_reg, do_s3_reg, do_latch_reg;
  logic do_latch_next;

  // A new level counts only once the second and third stages agree.
  always_comb begin
    do_latch_next = (do_s2_reg == do_s3_reg) ? do_s3_reg : do_latch_reg;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      do_s1_reg <= 1'b0;
      do_s2_reg <= 1'b0;
      do_s3_reg <= 1'b0;
      do_latch_reg <= 1'b0;
    end else begin
      do_s1_reg <= EEPROM_SERIAL_OUT;
      do_s2_reg <= do_s1_reg;
      do_s3_reg <= do_s2_reg;
      do_latch_reg <= do_latch_next;
    end
  end

  // ----------------------------------------------------------------
  // Autoload sequencer
  // ----------------------------------------------------------------
  load_state_t state_reg, state_next;
  logic [7:0] timer_reg, timer_next;
  logic sk_reg, sk_next;
  logic [4:0] bit_reg, bit_next;
  logic [3:0] word_reg, word_next;
  logic [15:0] shift_reg, shift_next;
  logic [8:0] cmd_reg, cmd_next;
  cfg_image_t cfg_reg, cfg_next;
  logic done_reg, done_next;
  logic tick;
  logic [15:0] word_val;

  // Each tick is one half period of the serial clock; data is sampled late
  // in the high half so the three-stage synchroniser has long settled.
  always_comb begin
    tick = (timer_reg == 8'h00);
    word_val = {shift_reg[14:0], do_latch_reg};
    state_next = state_reg;
    timer_next = tick ? 8'(HALF_CYCLES - 1) : timer_reg - 8'h01;
    sk_next = sk_reg;
    bit_next = bit_reg;
    word_next = word_reg;
    shift_next = shift_reg;
    cmd_next = cmd_reg;
    cfg_next = cfg_reg;
    case (state_reg)
      LD_START: begin
        if (tick) begin
          state_next = LD_SEND;
          cmd_next = {EE_READ_PREFIX, 2'h0, word_reg};
          bit_next = 5'h00;
        end
      end
      LD_SEND: begin
        if (tick) begin
          sk_next = ~sk_reg;
          if (sk_reg) begin
            cmd_next = {cmd_reg[7:0], 1'b0};
            if (bit_reg == 5'(CMD_BITS - 1)) begin
              state_next = LD_RECV;
              bit_next = 5'h00;
            end else begin
              bit_next = bit_reg + 5'h01;
            end
          end
        end
      end
      LD_RECV: begin
        if (tick) begin
          sk_next = ~sk_reg;
          if (sk_reg) begin
            shift_next = word_val;
            if (bit_reg == 5'(DATA_BITS - 1)) begin
              state_next = LD_GAP;
              case (word_reg)
                WORD_STATION_0: cfg_next.station_addr[15:0] = word_val;
                WORD_STATION_1: cfg_next.station_addr[31:16] = word_val;
                WORD_STATION_2: cfg_next.station_addr[47:32] = word_val;
                WORD_LAT_GNT: begin
                  cfg_next.max_latency = word_val[15:8];
                  cfg_next.min_grant = word_val[7:0];
                end
                WORD_SUBSYS_ID: cfg_next.subsys_id = word_val;
                WORD_SUBSYS_VENDOR: cfg_next.subsys_vendor_id = word_val;
                WORD_DEVICE_ID: cfg_next.device_id = word_val;
                WORD_VENDOR_ID: cfg_next.vendor_id = word_val;
                WORD_REV_OPTIONS: begin
                  cfg_next.power_wake_bootsize_byte = word_val[15:8];
                  cfg_next.revision = word_val[7:0];
                end
                default: cfg_next = cfg_reg;
              endcase
            end else begin
              bit_next = bit_reg + 5'h01;
            end
          end
        end
      end
      LD_GAP: begin
        if (tick) begin
          if (word_reg == 4'(LOAD_WORDS - 1)) begin
            state_next = LD_DONE;
          end else begin
            word_next = word_reg + 4'h1;
            state_next = LD_START;
          end
        end
      end
      LD_DONE: begin
        timer_next = 8'h00;
      end
      default: state_next = LD_DONE;
    endcase
    done_next = (state_next == LD_DONE);
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LD_START;
      timer_reg <= 8'h00;
      sk_reg <= 1'b0;
      bit_reg <= 5'h00;
      word_reg <= 4'h0;
      shift_reg <= 16'h0000;
      cmd_reg <= 9'h000;
      cfg_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      sk_reg <= sk_next;
      bit_reg <= bit_next;
      word_reg <= word_next;
      shift_reg <= shift_next;
      cmd_reg <= cmd_next;
      cfg_reg <= cfg_next;
      done_reg <= done_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial management register and EEPROM pins
  // ----------------------------------------------------------------
  logic [7:0] gpio_reg, gpio_next;
  logic ee_en_reg, ee_en_next;
  logic [15:0] sm_rdata_reg, sm_rdata_next;
  logic cs_pin_reg, cs_pin_next, sk_pin_reg, sk_pin_next, di_pin_reg, di_pin_next;
  logic oe_n_reg, oe_n_next;

  // The loader owns the pins until it finishes; after that software owns
  // them only while the enable bit is set, otherwise they are released.
  always_comb begin
    gpio_next = SM_WR ? SM_WDATA[7:0] : gpio_reg;
    ee_en_next = SM_WR ? SM_WDATA[SM_EE_EN_BIT] : ee_en_reg;
    sm_rdata_next = 16'h0000;
    sm_rdata_next[7:0] = gpio_reg;
    sm_rdata_next[SM_DO_BIT] = do_latch_reg;
    sm_rdata_next[SM_EE_EN_BIT] = ee_en_reg;
    if (!done_reg) begin
      cs_pin_next = (state_reg != LD_GAP);
      sk_pin_next = sk_reg;
      di_pin_next = (state_reg == LD_SEND) && cmd_reg[8];
      oe_n_next = 1'b0;
    end else if (ee_en_reg) begin
      cs_pin_next = gpio_reg[SM_CS_BIT];
      sk_pin_next = gpio_reg[SM_SK_BIT];
      di_pin_next = gpio_reg[SM_DI_BIT];
      oe_n_next = 1'b0;
    end else begin
      cs_pin_next = 1'b0;
      sk_pin_next = 1'b0;
      di_pin_next = 1'b0;
      oe_n_next = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      gpio_reg <= 8'h00;
      ee_en_reg <= 1'b0;
      sm_rdata_reg <= 16'h0000;
      cs_pin_reg <= 1'b0;
      sk_pin_reg <= 1'b0;
      di_pin_reg <= 1'b0;
      oe_n_reg <= 1'b0;
    end else begin
      gpio_reg <= gpio_next;
      ee_en_reg <= ee_en_next;
      sm_rdata_reg <= sm_rdata_next;
      cs_pin_reg <= cs_pin_next;
      sk_pin_reg <= sk_pin_next;
      di_pin_reg <= di_pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Signature register and configuration read handshake
  // ----------------------------------------------------------------
  logic sig_odd_reg, sig_odd_next;
  logic [7:0] sig_byte_reg, sig_byte_next;
  logic [15:0] drv_reg, drv_next;
  logic ack_reg, ack_next;

  // Reads alternate the built-in byte; configuration reads wait for the load to finish.
  always_comb begin
    sig_odd_next = SIG_RD ? ~sig_odd_reg : sig_odd_reg;
    sig_byte_next = sig_byte_reg;
    if (SIG_RD) begin
      sig_byte_next = sig_odd_reg ? SIG_ODD_BYTE : SIG_EVEN_BYTE;
    end
    drv_next = SIG_DRV_WR ? SIG_DRV_WDATA : drv_reg;
    ack_next = CFG_RD_REQ && done_reg && !ack_reg;
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sig_odd_reg <= 1'b1;
      sig_byte_reg <= 8'h00;
      drv_reg <= DRIVER_AREA_RESET;
      ack_reg <= 1'b0;
    end else begin
      sig_odd_reg <= sig_odd_next;
      sig_byte_reg <= sig_byte_next;
      drv_reg <= drv_next;
      ack_reg <= ack_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign SM_RDATA = sm_rdata_reg;
  assign SIG_RDATA = {drv_reg, 8'h00, sig_byte_reg};
  assign CFG_RD_ACK = ack_reg;
  assign LOAD_DONE = done_reg;
  assign CONFIG = cfg_reg;
  assign VENDOR_DEVICE_ID_REG = {cfg_reg.device_id, cfg_reg.vendor_id};
  assign REVISION_REG = {ETH_CLASS_CODE, cfg_reg.revision};
  assign EEPROM_CHIP_SELECT = cs_pin_reg;
  assign EEPROM_SERIAL_CLOCK_O = sk_pin_reg;
  assign EEPROM_SERIAL_CLOCK_OE_N = oe_n_reg;
  assign EEPROM_SERIAL_IN_O = di_pin_reg;
  assign EEPROM_SERIAL_IN_OE_N = oe_n_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_last_word_gap;
    (state_reg == LD_GAP) && tick && (word_reg == 4'(LOAD_WORDS - 1));
  endsequence
  property p_load_ends;
    s_last_word_gap |=> done_reg ##1 LOAD_DONE && $stable(cfg_reg);
  endproperty
  a_load_ends: assert property (p_load_ends) else $error("Load did not end after ninth word.");
  property p_cmd_form;
    (state_reg == LD_START) && tick |=> cmd_reg == {EE_READ_PREFIX, 2'h0, $past(word_reg)};
  endproperty
  a_cmd_form: assert property (p_cmd_form) else $error("Read command malformed.");
  property p_id_frozen;
    done_reg |=> $stable(VENDOR_DEVICE_ID_REG) && done_reg;
  endproperty
  a_id_frozen: assert property (p_id_frozen) else $error("Identification changed after load.");
  property p_class_code;
    REVISION_REG[31:8] == ETH_CLASS_CODE;
  endproperty
  a_class_code: assert property (p_class_code) else $error("Class code not built in.");
  property p_sig_alt;
    SIG_RD ##1 SIG_RD |=> SIG_RDATA[7:0] != $past(SIG_RDATA[7:0]);
  endproperty
  a_sig_alt: assert property (p_sig_alt) else $error("Signature did not alternate.");
  property p_drv_latch;
    SIG_DRV_WR |=> SIG_RDATA[31:16] == $past(SIG_DRV_WDATA);
  endproperty
  a_drv_latch: assert property (p_drv_latch) else $error("Driver area not latched.");
  property p_gpio;
    SM_WR |=> ##1 SM_RDATA[2:0] == $past(SM_WDATA[2:0], 2);
  endproperty
  a_gpio: assert property (p_gpio) else $error("General I/O bits not stored.");
  property p_pins;
    done_reg && ee_en_reg |=> EEPROM_CHIP_SELECT == $past(gpio_reg[0]) && !EEPROM_SERIAL_IN_OE_N
      && EEPROM_SERIAL_CLOCK_O == $past(gpio_reg[1]) && EEPROM_SERIAL_IN_O == $past(gpio_reg[2]);
  endproperty
  a_pins: assert property (p_pins) else $error("Pins do not follow serial management bits.");
  // Six quiet cycles cover the full pin-to-readback lag, also straight after a reset
  // has cleared the synchroniser while the pin sat high.
  property p_do_bit;
    $stable(EEPROM_SERIAL_OUT) [*6] |=> SM_RDATA[SM_DO_BIT] == $past(EEPROM_SERIAL_OUT, 2);
  endproperty
  a_do_bit: assert property (p_do_bit) else $error("Serial-out level not latched.");
  property p_ack_wait;
    CFG_RD_ACK |-> LOAD_DONE && $past(CFG_RD_REQ);
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("Configuration read answered early.");

endmodule  // eeprom_config_autoload
